// file: design/acc_alu.v
// Accumulator add/subtract and immediate-store execution unit.
`timescale 1ns/10ps
`include "alu_consts.vh"
// How it works
// - Add-with-carry forms accumulator plus memory byte plus the current carry.
// - After any add the carry becomes 1 on 8-bit overflow and 0 otherwise.
// - Plain add into the accumulator writes accumulator plus memory byte, ignoring the old carry.
// - Plain subtract writes accumulator minus memory byte into the accumulator.
// - After any subtract the carry becomes 0 on borrow and 1 when no borrow occurs.
// - Immediate stores to memory are accepted only for addresses 0x80 to 0x87.
module acc_alu (
	// Clock and reset
	input wire CLK,
	input wire ARST_N,
	// Instruction issue
	input wire OP_VALID,
	input wire [3:0] OP_CODE,
	input wire [7:0] OP_ADDR,
	input wire [7:0] OP_IMM,
	input wire [7:0] MEM_RDATA,
	// Results
	output reg [7:0] ACC,
	output reg CARRY,
	output reg MEM_WE,
	output reg [7:0] MEM_ADDR,
	output reg [7:0] MEM_WDATA,
	output reg OP_REJECT,
	output reg DONE
);
	wire [7:0] sum;
	wire cout;
	wire in_sysreg;
	reg sub;
	reg cin;
	reg op_adc;
	reg op_add;
	reg op_sbc;
	reg op_sub;
	reg op_store;
	reg op_load;
	reg to_mem;
	reg [7:0] acc_nxt;
	reg carry_nxt;
	reg we_nxt;
	reg [7:0] addr_nxt;
	reg [7:0] wdata_nxt;
	reg reject_nxt;
	reg done_nxt;

	// The window test looks at the issuing address, so a refused store never raises the write strobe.
	assign in_sysreg = (OP_ADDR >= `SYSREG_LO) && (OP_ADDR <= `SYSREG_HI);

	add_sub_core u_core (
		.a(ACC),
		.b(MEM_RDATA),
		.cin(cin),
		.sub(sub),
		.sum(sum),
		.cout(cout)
	);

	// Sort the operation into classes; an idle slot and an unknown code decode to nothing.
	// Memory-destination adds share the add classes and differ only in where the result lands.
	always @* begin
		op_adc = 1'b0;
		op_add = 1'b0;
		op_sbc = 1'b0;
		op_sub = 1'b0;
		op_store = 1'b0;
		op_load = 1'b0;
		to_mem = 1'b0;
		if (OP_VALID) begin
			case (OP_CODE)
				`OP_ADC_A: begin
					op_adc = 1'b1;
				end
				`OP_ADC_M: begin
					op_adc = 1'b1;
					to_mem = 1'b1;
				end
				`OP_ADD_A: begin
					op_add = 1'b1;
				end
				`OP_ADD_M: begin
					op_add = 1'b1;
					to_mem = 1'b1;
				end
				`OP_SBC_A: begin
					op_sbc = 1'b1;
				end
				`OP_SUB_A: begin
					op_sub = 1'b1;
				end
				`OP_MOVI_M: begin
					op_store = 1'b1;
				end
				`OP_LDA: begin
					op_load = 1'b1;
				end
				default: begin
					to_mem = 1'b0;
				end
			endcase
		end
	end

	// One adder serves every add and subtract class; only its operand sense and carry-in change.
	// Plain adds fall through with a zero carry-in, so an old carry cannot leak into the sum.
	always @* begin
		sub = 1'b0;
		cin = 1'b0;
		if (op_adc) begin
			cin = CARRY;
		end else if (op_sbc) begin
			// Borrow-style carry: a clear carry takes one more off.
			sub = 1'b1;
			cin = CARRY;
		end else if (op_sub) begin
			sub = 1'b1;
			cin = 1'b1;
		end
	end

	// Memory-destination adds leave the accumulator alone.
	always @* begin
		acc_nxt = ACC;
		if ((op_adc || op_add) && !to_mem) begin
			acc_nxt = sum;
		end else if (op_sbc || op_sub) begin
			acc_nxt = sum;
		end else if (op_load) begin
			acc_nxt = MEM_RDATA;
		end
	end

	// The adder's carry out reads as overflow for adds and as no-borrow for subtracts.
	always @* begin
		carry_nxt = CARRY;
		if (op_adc || op_add) begin
			carry_nxt = cout;
		end else if (op_sbc || op_sub) begin
			carry_nxt = cout;
		end
	end

	// Out-of-window stores are dropped rather than aliased into data memory.
	always @* begin
		we_nxt = 1'b0;
		wdata_nxt = sum;
		reject_nxt = 1'b0;
		if ((op_adc || op_add) && to_mem) begin
			we_nxt = 1'b1;
		end else if (op_store) begin
			if (in_sysreg) begin
				we_nxt = 1'b1;
				wdata_nxt = OP_IMM;
			end else begin
				reject_nxt = 1'b1;
			end
		end
	end

	// Address and completion follow every slot, so a refused store still reports as done.
	always @* begin
		addr_nxt = OP_ADDR;
		done_nxt = OP_VALID;
	end

	// Each output has a flip-flop of its own, so every port comes straight from a register.
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ACC <= `ACC_RST;
		end else begin
			ACC <= acc_nxt;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CARRY <= `CARRY_RST;
		end else begin
			CARRY <= carry_nxt;
		end
	end

	// The strobe lasts one cycle because its next value defaults low on every slot.
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			MEM_WE <= 1'b0;
		end else begin
			MEM_WE <= we_nxt;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			MEM_ADDR <= 8'h00;
		end else begin
			MEM_ADDR <= addr_nxt;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			MEM_WDATA <= 8'h00;
		end else begin
			MEM_WDATA <= wdata_nxt;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			OP_REJECT <= 1'b0;
		end else begin
			OP_REJECT <= reject_nxt;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			DONE <= 1'b0;
		end else begin
			DONE <= done_nxt;
		end
	end
endmodule // acc_alu

// file: design/add_sub_core.v
// Combinational 8-bit adder/subtractor with carry in and carry out.
`timescale 1ns/10ps
module add_sub_core (
	input wire [7:0] a,
	input wire [7:0] b,
	input wire cin,
	input wire sub,
	output wire [7:0] sum,
	output wire cout
);
	wire [8:0] full;
	// Subtraction is a plus inverted b; carry out high then means no borrow.
	assign full = {1'b0, a} + {1'b0, (sub ? ~b : b)} + {8'h00, cin};
	assign sum = full[7:0];
	assign cout = full[8];
endmodule // add_sub_core

// file: design/alu_consts.vh
// Constants for the accumulator add/subtract datapath.
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH
// Operation codes.
`define OP_NOP 4'h0
`define OP_ADC_A 4'h1
`define OP_ADC_M 4'h2
`define OP_ADD_A 4'h3
`define OP_ADD_M 4'h4
`define OP_SBC_A 4'h5
`define OP_SUB_A 4'h6
`define OP_MOVI_M 4'h7
`define OP_LDA 4'h8
// System register window for immediate stores.
`define SYSREG_LO 8'h80
`define SYSREG_HI 8'h87
// Reset values.
`define ACC_RST 8'h00
`define CARRY_RST 1'b0
`endif

// file: verification/acc_alu_bench.sv
// Random self-checking bench for the accumulator unit.
`timescale 1ns/10ps
`include "alu_consts.vh"
module acc_alu_bench;
logic CLK=0,ARST_N=0,OP_VALID=0,CARRY,MEM_WE,OP_REJECT,DONE,c=0;
logic [3:0] OP_CODE=0;
logic [7:0] OP_ADDR=0,OP_IMM=0,MEM_RDATA=0,ACC,MEM_ADDR,MEM_WDATA,a=0,d;
logic [18:0] e;
int n_mismatch=0,total_checks=0,cyc=0;
acc_alu dut (
	.CLK(CLK),
	.ARST_N(ARST_N),
	.OP_VALID(OP_VALID),
	.OP_CODE(OP_CODE),
	.OP_ADDR(OP_ADDR),
	.OP_IMM(OP_IMM),
	.MEM_RDATA(MEM_RDATA),
	.ACC(ACC),
	.CARRY(CARRY),
	.MEM_WE(MEM_WE),
	.MEM_ADDR(MEM_ADDR),
	.MEM_WDATA(MEM_WDATA),
	.OP_REJECT(OP_REJECT),
	.DONE(DONE)
);
always #25 CLK=~CLK;
always @(posedge CLK) if (++cyc>3000) begin
	n_mismatch++;
	wrap_up;
end
function logic [18:0] f(logic [3:0] o,logic [7:0] a,m,d,i,logic c);
	logic [8:0] p,q;
	p=a+m+((o==`OP_ADC_A||o==`OP_ADC_M)&&c);
	q=a-m-(o==`OP_SBC_A&&!c);
	case (o)
	`OP_ADC_A,`OP_ADD_A: f={p[7:0],p[8],10'h000};
	`OP_ADC_M,`OP_ADD_M: f={a,p[8],2'b10,p[7:0]};
	`OP_SBC_A,`OP_SUB_A: f={q[7:0],!q[8],10'h000};
	`OP_MOVI_M: f={a,c,d inside {[`SYSREG_LO:`SYSREG_HI]},!(d inside {[`SYSREG_LO:`SYSREG_HI]}),i};
	`OP_LDA: f={m,c,10'h000};
	default: f={a,c,10'h000};
	endcase
endfunction
task chk(logic [15:0] s,x);
	total_checks++;
	if (s!==x) begin
		n_mismatch++;
		$display("Error %0t: got %h want %h",$time,s,x);
	end
endtask
task wrap_up;
	$display("checks %0d mismatches %0d",total_checks,n_mismatch);
	if (n_mismatch==0&&total_checks>0) $display("NO MISMATCHES");
	else $display("MISMATCHES SEEN");
	$finish;
endtask
initial begin
	void'($urandom(34));
	repeat (16) @(negedge CLK);
	ARST_N=1;
	// The first forty operations sweep immediate stores across both window edges.
	for (int k=0;k<2000;k++) begin
		d=k<40?8'h7E+k%11:$urandom;
		OP_VALID=k<40||$urandom%4!=0;
		OP_CODE=k<40?`OP_MOVI_M:$urandom;
		OP_ADDR=d;
		OP_IMM=$urandom;
		MEM_RDATA=$urandom;
		e=f(OP_VALID?OP_CODE:`OP_NOP,a,MEM_RDATA,d,OP_IMM,c);
		@(negedge CLK);
		chk({ACC,CARRY,MEM_WE,OP_REJECT,DONE},{e[18:8],OP_VALID});
		if (e[9]) chk({MEM_WDATA,MEM_ADDR},{e[7:0],d});
		{a,c}=e[18:10];
	end
	wrap_up;
end
endmodule // acc_alu_bench

// file: verification/acc_alu_checker.sv
// Assertions for the accumulator add/subtract unit.
`timescale 1ns/10ps
`include "alu_consts.vh"
module acc_alu_checker (
	// Clock and reset
	input logic CLK,
	input logic ARST_N,
	// Issue side
	input logic OP_VALID,
	input logic [3:0] OP_CODE,
	input logic [7:0] OP_ADDR,
	input logic [7:0] OP_IMM,
	input logic [7:0] MEM_RDATA,
	// Result side
	input logic [7:0] ACC,
	input logic CARRY,
	input logic MEM_WE,
	input logic [7:0] MEM_ADDR,
	input logic [7:0] MEM_WDATA,
	input logic OP_REJECT,
	input logic DONE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	adc_acc_a: assert property (OP_VALID && OP_CODE == `OP_ADC_A |=>
		{CARRY, ACC} == $past({1'b0, ACC}) + $past(MEM_RDATA) + $past(CARRY)) else $error("adc bad");
	adc_mem_a: assert property (OP_VALID && OP_CODE == `OP_ADC_M |=>
		MEM_WE && $stable(ACC) && {CARRY, MEM_WDATA} == $past({1'b0, ACC}) + $past(MEM_RDATA) + $past(CARRY))
		else $error("adc mem bad");
	add_acc_a: assert property (OP_VALID && OP_CODE == `OP_ADD_A |=>
		{CARRY, ACC} == $past({1'b0, ACC}) + $past(MEM_RDATA)) else $error("add bad");
	add_mem_a: assert property (OP_VALID && OP_CODE == `OP_ADD_M |=>
		MEM_WE && $stable(ACC) && {CARRY, MEM_WDATA} == $past({1'b0, ACC}) + $past(MEM_RDATA)) else $error("add mem bad");
	sub_acc_a: assert property (OP_VALID && OP_CODE == `OP_SUB_A |=>
		ACC == $past(ACC - MEM_RDATA)) else $error("sub bad");
	sub_carry_a: assert property (OP_VALID && OP_CODE == `OP_SUB_A |=>
		CARRY == $past(ACC >= MEM_RDATA)) else $error("borrow bad");
	sbc_acc_a: assert property (OP_VALID && OP_CODE == `OP_SBC_A |=>
		{!CARRY, ACC} == $past({1'b0, ACC}) - $past(MEM_RDATA) - $past(!CARRY)) else $error("sbc bad");
	imm_store_a: assert property (OP_VALID && OP_CODE == `OP_MOVI_M |=>
		MEM_WE == $past(OP_ADDR inside {[`SYSREG_LO:`SYSREG_HI]}) && OP_REJECT != MEM_WE) else $error("store bad");
	store_data_a: assert property (OP_VALID && OP_CODE == `OP_MOVI_M && OP_ADDR inside {[`SYSREG_LO:`SYSREG_HI]} |=>
		MEM_WDATA == $past(OP_IMM) && MEM_ADDR == $past(OP_ADDR)) else $error("store data bad");
	done_pulse_a: assert property (OP_VALID |=> DONE) else $error("no done");
	cover property (OP_VALID && OP_CODE == `OP_MOVI_M && OP_ADDR == 8'h88);
	cover property (OP_VALID && OP_CODE == `OP_MOVI_M && OP_ADDR == 8'h87);
	cover property (OP_VALID && OP_CODE == `OP_ADC_A && CARRY);
	cover property (OP_VALID && OP_CODE == `OP_SBC_A && !CARRY);
endmodule // acc_alu_checker
bind acc_alu acc_alu_checker u_chk (
	.CLK(CLK),
	.ARST_N(ARST_N),
	.OP_VALID(OP_VALID),
	.OP_CODE(OP_CODE),
	.OP_ADDR(OP_ADDR),
	.OP_IMM(OP_IMM),
	.MEM_RDATA(MEM_RDATA),
	.ACC(ACC),
	.CARRY(CARRY),
	.MEM_WE(MEM_WE),
	.MEM_ADDR(MEM_ADDR),
	.MEM_WDATA(MEM_WDATA),
	.OP_REJECT(OP_REJECT),
	.DONE(DONE)
);
